// ### common/sdrp_regs.svh
`ifndef SDRP_REGS_SVH
`define SDRP_REGS_SVH

// Frame geometry
`define SDRP_FRAME_BITS 6'd40
`define SDRP_CNT_ONE 6'd1

// Register addresses, lower seven bits of the address byte
`define SDRP_ADDR_GLOBAL 7'h00
`define SDRP_ADDR_STATUS 7'h01
`define SDRP_ADDR_SINE1 7'h69
`define SDRP_ADDR_CHOP1 7'h6c
`define SDRP_ADDR_SINE2 7'h79
`define SDRP_ADDR_CHOP2 7'h7c

// Field positions
`define SDRP_GLOBAL_CONFIG_REG_SINGLE_BIT 0
`define SDRP_GLOBAL_CONFIG_REG_LOCK_BIT 1
`define SDRP_CHOP_3PH_BIT 27

// Reset values
`define SDRP_WORD_RESET 32'h0000_0000
`define SDRP_STATUS_RESET 8'h00
`define SDRP_STATUS_RSVD 1'b0

`endif

// ### common/sdrp_pkg.sv
package sdrp_pkg;

	// One received datagram, most significant bit first on the wire
	typedef struct packed {
		logic wr;
		logic [6:0] addr;
		logic [31:0] data;
	} sdrp_datagram_type;

	// One returned datagram: status snapshot then read data
	typedef struct packed {
		logic [7:0] status;
		logic [31:0] data;
	} sdrp_reply_type;

endpackage : sdrp_pkg

// ### design/sdrp_spi_port.sv
`include "sdrp_regs.svh"

// Function
// - Each transaction carries one 40-bit datagram of an address byte and four data bytes; shorter frames are dropped, longer ones keep their last 40 bits.
// - Registers are picked by a one-byte address whose lower seven bits select the register.
// - A cleared address byte top bit makes the datagram a read request.
// - A set address byte top bit makes the datagram a write that stores the payload.
// - Every register moves as a full 32-bit data field, unused bits carried but ignored.
// - Each register is write-only, read-write or read-only as defined for it.
// - Each of the two drivers can independently be configured for 3-phase operation.
// - The global config holds a single-driver flag making driver 1 run both power stages.
// - A lock, once applied, rejects further writes to the global config.
// - Bits go most significant first, sampled on rising and shifted out after falling clock edges.
// - Data asked for by a read comes back in the data field of the next datagram.
// - The top eight returned bits carry a status snapshot instead of the address.
module sdrp_spi_port (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic sck_i,
	input wire logic sdi_i,
	input wire logic select_n_i,
	input wire logic [6:0] status_flags_i,
	output logic sdo_o,
	output logic sdo_en_o,
	output logic single_driver_o,
	output logic config_lock_o,
	output logic [1:0] three_phase_o,
	output logic [1:0][31:0] chopper_config_o,
	output logic [1:0][31:0] sine_table_start_o
);

	logic [2:0] sck_sync_reg;
	logic [2:0] sdi_sync_reg;
	logic [2:0] sel_sync_reg;
	logic [39:0] shift_reg;
	logic sample_reg;
	logic [5:0] count_reg;
	logic [7:0] status_snap_reg;
	logic [31:0] read_data_reg;
	logic [31:0] global_config_reg;
	logic lock_reg;
	logic [1:0][31:0] chopper_config_reg;
	logic [1:0][31:0] sine_table_start_reg;

	wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
	wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
	wire sel_active = ~sel_sync_reg[1];
	wire frame_start = ~sel_sync_reg[1] & sel_sync_reg[2];
	wire frame_end = sel_sync_reg[1] & ~sel_sync_reg[2];
	wire sdi_bit = sdi_sync_reg[1];

	// Datagram decode of the last 40 bits seen
	sdrp_pkg::sdrp_datagram_type cmd;
	assign cmd = sdrp_pkg::sdrp_datagram_type'({shift_reg[38:0], sample_reg});
	wire frame_ok = frame_end & (count_reg == `SDRP_FRAME_BITS);
	wire wr_frame = frame_ok & cmd.wr;
	wire hit_global = cmd.addr == `SDRP_ADDR_GLOBAL;
	wire hit_status = cmd.addr == `SDRP_ADDR_STATUS;
	wire hit_chop1 = cmd.addr == `SDRP_ADDR_CHOP1;
	wire hit_chop2 = cmd.addr == `SDRP_ADDR_CHOP2;
	wire hit_sine1 = cmd.addr == `SDRP_ADDR_SINE1;
	wire hit_sine2 = cmd.addr == `SDRP_ADDR_SINE2;
	// lock gate on global config only, chopper and sine stores ungated
	wire wr_global = wr_frame & hit_global & ~lock_reg;
	wire [1:0] wr_chop = {wr_frame & hit_chop2, wr_frame & hit_chop1};
	wire [1:0] wr_sine = {wr_frame & hit_sine2, wr_frame & hit_sine1};

	// read access: sine start is write-only, status read-only
	wire [31:0] status_word = {25'h0, status_flags_i};
	wire [31:0] read_mux = hit_global ? global_config_reg :
		hit_status ? status_word :
		hit_chop1 ? chopper_config_reg[0] :
		hit_chop2 ? chopper_config_reg[1] : `SDRP_WORD_RESET;

	sdrp_pkg::sdrp_reply_type reply;
	assign reply = '{status: status_snap_reg, data: read_data_reg};

	// Pin synchronisers
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			sck_sync_reg <= 3'h7;
			sdi_sync_reg <= 3'h0;
			sel_sync_reg <= 3'h7;
		end else begin
			sck_sync_reg <= {sck_sync_reg[1:0], sck_i};
			sdi_sync_reg <= {sdi_sync_reg[1:0], sdi_i};
			sel_sync_reg <= {sel_sync_reg[1:0], select_n_i};
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			shift_reg <= 40'h00_0000_0000;
			sample_reg <= 1'b0;
		end else if (frame_start) begin
			shift_reg <= reply;
		end else if (sel_active & sck_rise) begin
			sample_reg <= sdi_bit;
		end else if (sel_active & sck_fall) begin
			shift_reg <= {shift_reg[38:0], sample_reg};
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			count_reg <= 6'h00;
		end else if (frame_start) begin
			count_reg <= 6'h00;
		end else if (sel_active & sck_rise & (count_reg != `SDRP_FRAME_BITS)) begin
			count_reg <= count_reg + `SDRP_CNT_ONE;
		end
	end

	// read pipeline and status latch, every accepted frame, writes mirror their data
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			read_data_reg <= `SDRP_WORD_RESET;
			status_snap_reg <= `SDRP_STATUS_RESET;
		end else if (frame_ok) begin
			read_data_reg <= cmd.wr ? cmd.data : read_mux;
			status_snap_reg <= {`SDRP_STATUS_RSVD, status_flags_i};
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			global_config_reg <= `SDRP_WORD_RESET;
			lock_reg <= 1'b0;
		end else if (wr_global) begin
			global_config_reg <= cmd.data;
			lock_reg <= cmd.data[`SDRP_GLOBAL_CONFIG_REG_LOCK_BIT];
		end
	end

	// full words per driver, independent channels
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			chopper_config_reg <= {2{`SDRP_WORD_RESET}};
			sine_table_start_reg <= {2{`SDRP_WORD_RESET}};
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_chop[i]) begin
					chopper_config_reg[i] <= cmd.data;
				end
				if (wr_sine[i]) begin
					sine_table_start_reg[i] <= cmd.data;
				end
			end
		end
	end

	// Output flops
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			sdo_o <= 1'b0;
			sdo_en_o <= 1'b0;
			single_driver_o <= 1'b0;
			config_lock_o <= 1'b0;
			three_phase_o <= 2'h0;
			chopper_config_o <= {2{`SDRP_WORD_RESET}};
			sine_table_start_o <= {2{`SDRP_WORD_RESET}};
		end else begin
			// MSB first, next bit after falling clock
			if (frame_start) begin
				sdo_o <= reply[39];
			end else if (sel_active & sck_fall) begin
				sdo_o <= shift_reg[39];
			end
			sdo_en_o <= sel_active;
			single_driver_o <= global_config_reg[`SDRP_GLOBAL_CONFIG_REG_SINGLE_BIT];
			config_lock_o <= lock_reg;
			three_phase_o <= {chopper_config_reg[1][`SDRP_CHOP_3PH_BIT], chopper_config_reg[0][`SDRP_CHOP_3PH_BIT]};
			chopper_config_o <= chopper_config_reg;
			sine_table_start_o <= sine_table_start_reg;
		end
	end

	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	sequence seq_write_commit;
		frame_ok ##0 cmd.wr;
	endsequence

	sequence seq_read_commit;
		frame_ok ##0 !cmd.wr;
	endsequence

	AST_FRAME_LEN: assert property (frame_ok |-> count_reg == `SDRP_FRAME_BITS)
		else $error("Frame accepted with wrong bit count");
	AST_SHORT_FRAME: assert property (frame_end && count_reg != `SDRP_FRAME_BITS |=> $stable(read_data_reg))
		else $error("Short frame changed read data");
	AST_READ_NO_STORE: assert property (seq_read_commit |=> $stable(chopper_config_reg)
		&& $stable(global_config_reg))
		else $error("Read datagram altered a register");
	AST_WRITE_STORE: assert property (seq_write_commit ##0 hit_chop1 |=> chopper_config_reg[0] == $past(cmd.data))
		else $error("Write did not store payload");
	AST_LOCK_HOLD: assert property (lock_reg |=> $stable(global_config_reg) && lock_reg)
		else $error("Locked global config changed");
	AST_RO_IGNORE: assert property (seq_write_commit ##0 hit_status |=> $stable(chopper_config_reg)
		&& $stable(sine_table_start_reg) && $stable(global_config_reg))
		else $error("Write to read-only address changed state");
	AST_PIPELINE: assert property (seq_read_commit ##0 hit_chop2 |=> read_data_reg == $past(chopper_config_reg[1]))
		else $error("Read data not returned for next frame");
	AST_MIRROR: assert property (seq_write_commit |=> read_data_reg == $past(cmd.data))
		else $error("Write data not mirrored");
	AST_STATUS_TOP: assert property (frame_start |=> shift_reg[39:32] == $past(status_snap_reg)
		##1 sdo_o == shift_reg[39] || !sel_active)
		else $error("Status snapshot not at top of reply");
	AST_THREE_PHASE: assert property (wr_chop[0] |=> ##1
		three_phase_o[0] == $past(cmd.data[`SDRP_CHOP_3PH_BIT], 2))
		else $error("Three-phase output does not follow config");
	AST_SINGLE_DRV: assert property (wr_global |=> ##1
		single_driver_o == $past(cmd.data[`SDRP_GLOBAL_CONFIG_REG_SINGLE_BIT], 2))
		else $error("Single-driver output does not follow config");
	AST_SDO_FALL: assert property (sel_active && sck_fall && !frame_start |=> sdo_o == $past(shift_reg[39]))
		else $error("Serial output did not follow falling clock");

endmodule : sdrp_spi_port

// ### tb/sdrp_host_model.sv
// Host side SPI master, mode 3, clock idles high
module sdrp_host_model (
	input wire logic clock_i,
	input wire logic sdo_i,
	output logic sck_o,
	output logic sdi_o,
	output logic select_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus at time zero
	initial begin
		sck_o = 1'b1;
		sdi_o = 1'b0;
		select_n_o = 1'b1;
	end
	task automatic xfer(input logic [47:0] tx, input int nbits, output logic [39:0] rx);
		rx = '0;
		@(posedge clock_i);
		select_n_o <= 1'b0;
		repeat (6) @(posedge clock_i);
		for (int i = nbits - 1; i >= 0; i--) begin
			@(posedge clock_i);
			sck_o <= 1'b0;
			sdi_o <= tx[i];
			repeat (4) @(posedge clock_i);
			// Sample just before the rising clock
			@(negedge clock_i);
			rx = {rx[38:0], sdo_i};
			@(posedge clock_i);
			sck_o <= 1'b1;
			repeat (4) @(posedge clock_i);
		end
		@(posedge clock_i);
		select_n_o <= 1'b1;
		sdi_o <= ~sdi_o; // Released line does not hold its value
		repeat (12) @(posedge clock_i);
	endtask : xfer
endmodule : sdrp_host_model

// ### tb/sdrp_spi_port_tb.sv
// Bench for the datagram port
module sdrp_spi_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_i, reset_i, sck, sdi, sel_n, sdo, sdo_en, single, lock;
	logic [6:0] flags;
	logic [1:0] tph;
	logic [1:0][31:0] chop, sine;
	logic [39:0] rx;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	// Clock generation
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	sdrp_spi_port i_sdrp_spi_port (.clock_i(clock_i), .reset_i(reset_i), .sck_i(sck), .sdi_i(sdi),
		.select_n_i(sel_n), .status_flags_i(flags), .sdo_o(sdo), .sdo_en_o(sdo_en),
		.single_driver_o(single), .config_lock_o(lock), .three_phase_o(tph),
		.chopper_config_o(chop), .sine_table_start_o(sine));
	sdrp_host_model i_sdrp_host_model (.clock_i(clock_i), .sdo_i(sdo), .sck_o(sck), .sdi_o(sdi),
		.select_n_o(sel_n));
	task automatic test_done();
		if (err_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	// Hang guard
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		i_sdrp_host_model.xfer({8'h00, 1'b1, a, d}, 40, rx);
	endtask : wr
	task automatic rd(input logic [6:0] a);
		i_sdrp_host_model.xfer({8'h00, 1'b0, a, 32'h0000_0000}, 40, rx);
	endtask : rd
	task automatic t_write();
		wr(7'h6c, 32'h0800_00a5);
		wr(7'h69, 32'h0000_0155);
		chk(chop[0], 32'h0800_00a5);
		chk(sine[0], 32'h0000_0155);
		chk(tph, 2'h1);
		wr(7'h7c, 32'h0800_0000);
		chk(tph, 2'h3);
		chk(rx, {1'b0, flags, 32'h0000_0155});
	endtask : t_write
	task automatic t_read();
		fork
			rd(7'h6c);
			begin
				repeat (20) @(negedge clock_i);
				chk(sdo_en, 1'b1);
			end
		join
		chk(sdo_en, 1'b0);
		rd(7'h01);
		chk(rx[31:0], 32'h0800_00a5);
		flags <= 7'h33;
		rd(7'h69);
		chk(rx, 40'h5a_0000_005a);
		rd(7'h00);
		chk(rx, 40'h33_0000_0000);
	endtask : t_read
	task automatic t_frame();
		i_sdrp_host_model.xfer({9'h001, 7'h6c, 32'h0000_0001}, 39, rx);
		chk(chop[0], 32'h0800_00a5);
		i_sdrp_host_model.xfer({8'h01, 1'b1, 7'h7c, 32'h1234_5678}, 41, rx);
		chk({tph, chop[1]}, {2'h1, 32'h1234_5678});
		wr(7'h01, 32'hffff_ffff);
		wr(7'h05, 32'hffff_ffff);
		chk({single, lock, tph, chop[0]}, {4'h1, 32'h0800_00a5});
	endtask : t_frame
	task automatic t_lock();
		wr(7'h00, 32'h0000_0001);
		chk(single, 1'b1);
		rd(7'h00);
		wr(7'h00, 32'h0000_0003);
		chk(rx[31:0], 32'h0000_0001);
		chk(lock, 1'b1);
		wr(7'h00, 32'h0000_0000);
		chk({single, lock}, 2'h3);
		wr(7'h79, 32'h0000_02aa);
		chk(sine[1], 32'h0000_02aa);
		chk(sine[0], 32'h0000_0155);
	endtask : t_lock
	// Main sequence
	initial begin
		reset_i = 1'b1;
		flags = 7'h5a;
		repeat (16) @(posedge clock_i);
		chk({single, lock, tph, sdo_en, chop[0]}, '0);
		reset_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		t_write();
		t_read();
		t_frame();
		t_lock();
		test_done();
	end
endmodule : sdrp_spi_port_tb
